// File: design/ivr_regs.svh
/*
  register map, field positions, reset values and timing counts of the
  interrupt vector relocation block; assumes a 10 MHz core clock.
*/
`ifndef IVR_REGS_SVH
`define IVR_REGS_SVH

`define IVR_CTRL_ADDR      8'H35
`define IVR_CTRL_RESET     8'H00
`define IVR_BIT_UNLOCK     0
`define IVR_BIT_SELECT     1
`define IVR_READ_ZERO      8'H00
`define IVR_CLK_NS         100
`define IVR_WINDOW_CYCLES  3'H4
`define IVR_HOLD_CYCLES    3'H2
`define IVR_CNT_ONE        3'H1
`define IVR_CNT_ZERO       3'H0
`define IVR_FLASH_WORDS_S  16'H4000
`define IVR_FLASH_WORDS_L  16'H8000
`define IVR_BOOT_MIN_WORDS 16'H0100
`define IVR_VECTOR_OFFSET  16'H0002
`define IVR_ADDR_ZERO      16'H0000
`define IVR_FUSE_IDLE      5'H1F
`define IVR_BOOT_SIZE_MAX  2'H3

`endif

// File: design/ivr_pkg.sv
/*
  types shared by the interrupt vector relocation block;
  assumes ivr_regs.svh supplies all numeric constants.
*/
package ivr_pkg;
    // phase of the unlock and relocation sequence
    typedef enum logic [1:0] {
        WIN_IDLE,
        WIN_OPEN,
        WIN_HOLD
    } winState_type;
endpackage

// File: design/interrupt_vector_relocation.sv
/*
  interrupt vector relocation: control register, timed unlock of the
  vector select bit, interrupt blocking and reset/vector addresses.
  assumes a single 10 MHz core clock, a plain register port driven on that
  clock, fuse and lock bits from outside the clock domain (active low,
  0 = programmed) and a word program counter on the core clock.
*/
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "ivr_regs.svh"

module interrupt_vector_relocation #(
    parameter bit LARGE_FLASH = 1'b0
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    // fuses and lock bits, active low
    input  wire logic        bootResetFuse,
    input  wire logic [1:0]  bootSizeFuses,
    input  wire logic        appSectionLockBit,
    input  wire logic        bootSectionLockBit,
    // core execution state
    input  wire logic [15:0] progCounter,
    // placement and blocking
    output logic             vectorTableSelect,
    output logic             vectorChangeUnlock,
    output logic [15:0]      vectorStart,
    output logic [15:0]      resetAddress,
    output logic             interruptBlock
);

    // fuse pins are static but asynchronous: three stages, agree to accept
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic [4:0] syncC;
    logic [4:0] fuseState;
    logic       windowWrite;
    logic       ctrlWrite;
    logic       ctrlRead;
    logic       wantUnlock;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic       next_unlock;
    logic       next_select;
    logic [15:0] bootStart;
    logic       inBoot;
    logic       lockBlock;
    ivr_pkg::winState_type state;
    ivr_pkg::winState_type next_state;

    // boot section start from flash size and boot-size fuses
    // the boot section sits at the top of flash and halves per size step
    function automatic logic [15:0] boot_start(input logic [1:0] size);
        logic [15:0] words;
        words = LARGE_FLASH ? `IVR_FLASH_WORDS_L : `IVR_FLASH_WORDS_S;
        return words - (`IVR_BOOT_MIN_WORDS << (`IVR_BOOT_SIZE_MAX - size));
    endfunction

    // three-stage sampling of fuse and lock pins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            syncA <= `IVR_FUSE_IDLE;
            syncB <= `IVR_FUSE_IDLE;
            syncC <= `IVR_FUSE_IDLE;
        end else begin
            syncA <= {bootResetFuse, bootSizeFuses, appSectionLockBit, bootSectionLockBit};
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // accepted fuse value, updated per bit when stages two and three agree
    // a pin caught mid-change simply waits one more cycle before it counts
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fuseState <= `IVR_FUSE_IDLE;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (syncB[i] == syncC[i]) begin
                    fuseState[i] <= syncC[i];
                end
            end
        end
    end

    assign ctrlWrite  = regWrite && (regAddr == `IVR_CTRL_ADDR);
    assign ctrlRead   = regRead && (regAddr == `IVR_CTRL_ADDR);
    assign wantUnlock = regWdata[`IVR_BIT_UNLOCK];
    // select write accepted only while the window is open
    assign windowWrite = ctrlWrite && !wantUnlock && (state == ivr_pkg::WIN_OPEN);

    // sequence next state: open, hold after select, timeout
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_unlock = vectorChangeUnlock;
        next_select = vectorTableSelect;
        // a fresh unlock write wins over the timeout: set beats clear
        if (ctrlWrite && wantUnlock) begin
            next_state  = ivr_pkg::WIN_OPEN;
            next_cnt    = `IVR_WINDOW_CYCLES;
            next_unlock = 1'b1;
        end else if (windowWrite) begin
            next_select = regWdata[`IVR_BIT_SELECT];
            next_unlock = 1'b0;
            next_state  = ivr_pkg::WIN_HOLD;
            next_cnt    = `IVR_HOLD_CYCLES;
        end else if (state != ivr_pkg::WIN_IDLE) begin
            if (cnt == `IVR_CNT_ONE) begin
                next_state  = ivr_pkg::WIN_IDLE;
                next_cnt    = `IVR_CNT_ZERO;
                next_unlock = 1'b0;
            end else begin
                next_cnt = cnt - `IVR_CNT_ONE;
            end
        end
        case (next_state)
            ivr_pkg::WIN_IDLE: next_unlock = 1'b0;
            ivr_pkg::WIN_OPEN: next_unlock = next_unlock;
            ivr_pkg::WIN_HOLD: next_unlock = 1'b0;
            default:           next_unlock = 1'b0;
        endcase
    end

    // sequence state and counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ivr_pkg::WIN_IDLE;
            cnt   <= `IVR_CNT_ZERO;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // control register bits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vectorTableSelect  <= 1'(`IVR_CTRL_RESET >> `IVR_BIT_SELECT);
            vectorChangeUnlock <= 1'(`IVR_CTRL_RESET >> `IVR_BIT_UNLOCK);
        end else begin
            vectorTableSelect  <= next_select;
            vectorChangeUnlock <= next_unlock;
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdata <= `IVR_READ_ZERO;
        end else if (ctrlRead) begin
            regRdata <= `IVR_READ_ZERO;
            regRdata[`IVR_BIT_SELECT] <= vectorTableSelect;
            regRdata[`IVR_BIT_UNLOCK] <= vectorChangeUnlock;
        end else begin
            regRdata <= `IVR_READ_ZERO;
        end
    end

    // lock-bit blocking depends on vector placement and executing section
    assign bootStart = boot_start(fuseState[3:2]);
    assign inBoot    = progCounter >= bootStart;
    assign lockBlock = (vectorTableSelect && !fuseState[1] && !inBoot)
                    || (!vectorTableSelect && !fuseState[0] && inBoot);

    // servicing block only; the global enable lives elsewhere, untouched
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            interruptBlock <= 1'b0;
        end else begin
            interruptBlock <= (next_state != ivr_pkg::WIN_IDLE) || lockBlock;
        end
    end

    // reset entry and vector table start
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vectorStart  <= `IVR_VECTOR_OFFSET;
            resetAddress <= `IVR_ADDR_ZERO;
        end else begin
            vectorStart  <= (next_select ? bootStart : `IVR_ADDR_ZERO)
                          + `IVR_VECTOR_OFFSET;
            resetAddress <= fuseState[4] ? `IVR_ADDR_ZERO : bootStart;
        end
    end

    // named steps of the unlock and relocation sequence
    sequence unlockWrite;
        ctrlWrite && wantUnlock;
    endsequence

    sequence noCtrlWrite4;
        !ctrlWrite [*4];
    endsequence

    // blocking must cover the shortest path: select written at once
    sequence blockHeld3;
        interruptBlock [*3];
    endsequence

    // blocking stays up for the instruction after the select write
    sequence holdAfterSelect;
        interruptBlock ##1 interruptBlock;
    endsequence

    // window timing, interrupt blocking, select writes, vector and reset addresses, unused read bits
    a_unlock_timeout: assert property (@(posedge sys_clk) disable iff (sys_rst)
        unlockWrite ##1 noCtrlWrite4 |=> !vectorChangeUnlock && (state == ivr_pkg::WIN_IDLE))
        else $error("unlock did not expire after four cycles");

    a_block_timeout: assert property (@(posedge sys_clk) disable iff (sys_rst)
        unlockWrite ##1 noCtrlWrite4 |-> interruptBlock)
        else $error("interrupts released before the window ran out");

    a_unlock_held: assert property (@(posedge sys_clk) disable iff (sys_rst)
        unlockWrite ##1 (!ctrlWrite [*3]) |-> vectorChangeUnlock)
        else $error("unlock dropped early");

    a_unlock_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
        unlockWrite |=> vectorChangeUnlock && interruptBlock && (cnt == `IVR_WINDOW_CYCLES))
        else $error("unlock write did not open a fresh window");

    a_count_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state != ivr_pkg::WIN_IDLE)
            |-> (cnt != `IVR_CNT_ZERO) && (cnt <= `IVR_WINDOW_CYCLES))
        else $error("window counter out of range");

    a_block_span: assert property (@(posedge sys_clk) disable iff (sys_rst)
        unlockWrite |=> blockHeld3)
        else $error("interrupts not blocked during window");

    a_hold_span: assert property (@(posedge sys_clk) disable iff (sys_rst)
        windowWrite |=> holdAfterSelect)
        else $error("interrupts released right after the select write");

    a_select_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state == ivr_pkg::WIN_IDLE) && !ctrlWrite |=> $stable(vectorTableSelect))
        else $error("select changed without unlock");

    a_select_taken: assert property (@(posedge sys_clk) disable iff (sys_rst)
        windowWrite |=> (vectorTableSelect == $past(regWdata[`IVR_BIT_SELECT]))
            && !vectorChangeUnlock ##1 interruptBlock)
        else $error("select write in window not taken");

    a_select_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctrlWrite && !wantUnlock && (state != ivr_pkg::WIN_OPEN)
            |=> $stable(vectorTableSelect))
        else $error("select write outside window took effect");

    a_vector_place: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ##1 !vectorTableSelect |-> vectorStart == `IVR_VECTOR_OFFSET)
        else $error("vectors not at flash bottom");

    a_vector_boot: assert property (@(posedge sys_clk) disable iff (sys_rst)
        vectorTableSelect && $stable(fuseState)
            |-> vectorStart == bootStart + `IVR_VECTOR_OFFSET)
        else $error("vectors not at boot start");

    a_reset_entry: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $stable(fuseState) |-> resetAddress == (fuseState[4] ? `IVR_ADDR_ZERO : bootStart))
        else $error("reset entry wrong for fuse level");

    a_lock_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
        lockBlock |=> interruptBlock)
        else $error("lock-bit blocking missing");

    a_read_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctrlRead |=> regRdata[7:2] == 6'H00)
        else $error("unused bits not read as zero");

    a_release_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state == ivr_pkg::WIN_IDLE) && !lockBlock && !ctrlWrite |=> !interruptBlock)
        else $error("blocking held with no cause");

    // register port read-back
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ctrlRead |=> regRdata == `IVR_READ_ZERO)
        else $error("read data not zero outside a read");

    a_read_bits: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctrlRead |=> (regRdata[`IVR_BIT_SELECT] == $past(vectorTableSelect))
            && (regRdata[`IVR_BIT_UNLOCK] == $past(vectorChangeUnlock)))
        else $error("read data do not match the register bits");

endmodule // interrupt_vector_relocation

// File: verification/testbench.sv
/*
  self-checking testbench of the interrupt vector relocation block.
  assumes the design files are compiled first and ivr_regs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "ivr_regs.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nErrors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module testbench;
    logic        sys_clk            = 1'b0;
    logic        sys_rst            = 1'b1;
    logic [7:0]  regAddr            = 8'H00;
    logic [7:0]  regWdata           = 8'H00;
    logic        regWrite           = 1'b0;
    logic        regRead            = 1'b0;
    logic        bootResetFuse      = 1'b1;
    logic [1:0]  bootSizeFuses      = 2'H0;
    logic        appSectionLockBit  = 1'b1;
    logic        bootSectionLockBit = 1'b1;
    logic [15:0] progCounter        = 16'H0000;
    logic [7:0]  regRdata;
    logic        vectorTableSelect;
    logic        vectorChangeUnlock;
    logic [15:0] vectorStart;
    logic [15:0] resetAddress;
    logic        interruptBlock;
    logic [7:0]  addr;
    int          nErrors            = 0;
    int          samplesChecked     = 0;

    // block under test, small flash
    interrupt_vector_relocation #(.LARGE_FLASH(1'b0)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .bootResetFuse(bootResetFuse), .bootSizeFuses(bootSizeFuses),
        .appSectionLockBit(appSectionLockBit), .bootSectionLockBit(bootSectionLockBit),
        .progCounter(progCounter), .vectorTableSelect(vectorTableSelect),
        .vectorChangeUnlock(vectorChangeUnlock), .vectorStart(vectorStart),
        .resetAddress(resetAddress), .interruptBlock(interruptBlock)
    );

    // 10 MHz core clock
    always #50 sys_clk = ~sys_clk;

    // boot section start in a 16K-word flash
    function automatic logic [15:0] bootStart(input logic [1:0] v);
        return 16'H4000 - (16'H0100 << (2'H3 - v));
    endfunction

    // wait for edges, then step off them
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one write cycle; keep holds the strobe for a following write
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit keep = 1'b0);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        step(1);
        if (!keep) regWrite <= 1'b0;
    endtask

    // one read cycle, data compared in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        step(1);
        regRead <= 1'b0;
        `CHK("regRdata", e, regRdata)
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog against a hung sequence
    initial begin
        repeat (3000) @(posedge sys_clk);
        nErrors++;
        end_sim();
    end

    // main sequence
    initial begin
        void'($urandom(32'h3D4D));
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst <= 1'b0;
        step(4);
        `CHK("vectorStart", 16'H0002, vectorStart)
        rd(`IVR_CTRL_ADDR, 8'H00);
        wr(`IVR_CTRL_ADDR, 8'HFE);
        rd(`IVR_CTRL_ADDR, 8'H00);
        wr(`IVR_CTRL_ADDR, 8'H01, 1'b1);
        `CHK("interruptBlock", 1'b1, interruptBlock)
        wr(`IVR_CTRL_ADDR, 8'H02);
        `CHK("vectorTableSelect", 1'b1, vectorTableSelect)
        `CHK("vectorChangeUnlock", 1'b0, vectorChangeUnlock)
        `CHK("vectorStart", 16'H3802, vectorStart)
        `CHK("resetAddress", 16'H0000, resetAddress)
        `CHK("interruptBlock", 1'b1, interruptBlock)
        rd(`IVR_CTRL_ADDR, 8'H02);
        step(2);
        `CHK("interruptBlock", 1'b0, interruptBlock)
        wr(`IVR_CTRL_ADDR, 8'H01);
        step(2);
        wr(`IVR_CTRL_ADDR, 8'H01);
        step(3);
        `CHK("vectorChangeUnlock", 1'b1, vectorChangeUnlock)
        `CHK("interruptBlock", 1'b1, interruptBlock)
        step(1);
        `CHK("vectorChangeUnlock", 1'b0, vectorChangeUnlock)
        `CHK("interruptBlock", 1'b0, interruptBlock)
        wr(`IVR_CTRL_ADDR, 8'H00);
        `CHK("vectorTableSelect", 1'b1, vectorTableSelect)
        // lock blocking with vectors in the boot section, then at the flash bottom
        appSectionLockBit <= 1'b0;
        progCounter <= 16'H0100;
        step(6);
        `CHK("interruptBlock", 1'b1, interruptBlock)
        progCounter <= 16'H3900;
        step(3);
        `CHK("interruptBlock", 1'b0, interruptBlock)
        appSectionLockBit <= 1'b1;
        wr(`IVR_CTRL_ADDR, 8'H01, 1'b1);
        wr(`IVR_CTRL_ADDR, 8'H00);
        `CHK("vectorStart", 16'H0002, vectorStart)
        bootSectionLockBit <= 1'b0;
        step(6);
        `CHK("interruptBlock", 1'b1, interruptBlock)
        progCounter <= 16'H0100;
        step(3);
        `CHK("interruptBlock", 1'b0, interruptBlock)
        bootSectionLockBit <= 1'b1;
        // reset entry for every boot size with the fuse programmed
        bootResetFuse <= 1'b0;
        for (int v = 0; v < 4; v++) begin
            bootSizeFuses <= v[1:0];
            step(6);
            `CHK("resetAddress", bootStart(v[1:0]), resetAddress)
        end
        bootSizeFuses <= 2'H0;
        wr(`IVR_CTRL_ADDR, 8'H01, 1'b1);
        wr(`IVR_CTRL_ADDR, 8'H02);
        step(6);
        `CHK("vectorStart", 16'H3802, vectorStart)
        `CHK("resetAddress", 16'H3800, resetAddress)
        bootResetFuse <= 1'b1;
        step(6);
        `CHK("resetAddress", 16'H0000, resetAddress)
        // unmapped traffic leaves the register alone
        for (int i = 0; i < 40; i++) begin
            addr = 8'($urandom_range(0, 255));
            if (addr == `IVR_CTRL_ADDR) addr = 8'H36;
            progCounter <= 16'($urandom);
            wr(addr, 8'($urandom));
            rd(addr, 8'H00);
            `CHK("vectorChangeUnlock", 1'b0, vectorChangeUnlock)
            `CHK("interruptBlock", 1'b0, interruptBlock)
        end
        // reset in mid-run clears the register
        sys_rst <= 1'b1;
        step(1);
        sys_rst <= 1'b0;
        step(4);
        `CHK("vectorTableSelect", 1'b0, vectorTableSelect)
        rd(`IVR_CTRL_ADDR, 8'H00);
        end_sim();
    end
endmodule // testbench
